/* File: hdl/cstat_pkg.sv */
// Package of constants for the charger status register bank
`default_nettype none
package cstat_pkg;
   // Serial target address
   localparam logic [6:0] CSTAT_TARGET_ADDR = 7'h6b;
   // Register addresses
   localparam logic [7:0] CSTAT_CHARGE_REG_OFS = 8'h00;
   localparam logic [7:0] CSTAT_FAULT_REG_OFS = 8'h01;
   localparam logic [7:0] CSTAT_SENSOR_REG_OFS = 8'h02;
   // Charge regulation status bits
   localparam int CSTAT_CV_BIT = 6;
   localparam int CSTAT_DONE_BIT = 5;
   localparam int CSTAT_ILIM_BIT = 4;
   localparam int CSTAT_VREG_BIT = 2;
   localparam int CSTAT_THERM_BIT = 1;
   localparam int CSTAT_PGOOD_BIT = 0;
   // Fault and thermal status bits
   localparam int CSTAT_OVP_BIT = 7;
   localparam int CSTAT_OCP_BIT = 5;
   localparam int CSTAT_UVLO_BIT = 4;
   localparam int CSTAT_COLD_BIT = 3;
   localparam int CSTAT_COOL_BIT = 2;
   localparam int CSTAT_WARM_BIT = 1;
   localparam int CSTAT_HOT_BIT = 0;
   // Sensor open status bit
   localparam int CSTAT_OPEN_BIT = 0;
   // Reset value of every status register and of unmapped reads
   localparam logic [7:0] CSTAT_REG_RESET = 8'h00;
   // Bits per serial byte
   localparam logic [3:0] CSTAT_BYTE_BITS = 4'h8;
   // Serial engine states
   typedef enum logic [6:0] {
      CSTAT_IDLE = 7'h01, // Waiting for a start condition
      CSTAT_ADDR = 7'h02, // Receiving address byte
      CSTAT_PTR = 7'h04, // Receiving register pointer
      CSTAT_WDATA = 7'h08, // Receiving data bytes, discarded
      CSTAT_ACK = 7'h10, // Driving acknowledge
      CSTAT_READ = 7'h20, // Shifting out a data byte
      CSTAT_RACK = 7'h40 // Sampling the host acknowledge
   } cstat_state_type;
endpackage : cstat_pkg
`default_nettype wire

/* File: hdl/cstat_status_regs.sv */
// Charger status register bank with its serial target engine
`default_nettype none
module cstat_status_regs #(
   parameter logic [6:0] TARGET_ADDR = cstat_pkg::CSTAT_TARGET_ADDR
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Charge regulation conditions
   input wire logic constant_voltage_active,
   input wire logic charge_done,
   input wire logic input_current_limit_active,
   input wire logic input_voltage_regulation_active,
   input wire logic die_thermal_regulation_active,
   input wire logic input_power_good,
   // Fault conditions
   input wire logic input_overvoltage_active,
   input wire logic battery_overcurrent_active,
   input wire logic battery_undervoltage_active,
   // Thermistor comparator zones
   input wire logic thermistor_cold_zone,
   input wire logic thermistor_cool_zone,
   input wire logic thermistor_warm_zone,
   input wire logic thermistor_hot_zone,
   input wire logic thermistor_open_detect,
   // Charge control derived from thermistor zones
   output logic charge_suspend,
   output logic charge_current_reduce,
   output logic charge_voltage_reduce,
   // Serial bus pins, data is open drain
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n
);
   // Reserved and general-call style addresses cannot be served
   if (TARGET_ADDR < 7'h08 || TARGET_ADDR > 7'h77) begin : g_addr_check
      $error("Target address lies in a reserved range");
   end

   // Live status snapshots
   logic [7:0] charge_stat_r;
   logic [7:0] fault_stat_r;
   logic [7:0] sensor_stat_r;
   // Charge control flops
   logic suspend_r;
   logic cur_red_r;
   logic volt_red_r;
   // Pin history for edge and condition detection
   logic scl_d_r;
   logic sda_d_r;
   // Serial engine state
   cstat_pkg::cstat_state_type state_r;
   cstat_pkg::cstat_state_type after_ack_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] rx_r;
   logic [7:0] tx_r;
   logic [7:0] ptr_r;
   logic sda_oe_n_r;
   logic sda_out_r;
   // Bus events
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [7:0] rd_data;

   assign scl_rise = scl_in & ~scl_d_r;
   assign scl_fall = ~scl_in & scl_d_r;
   assign start_cond = scl_in & scl_d_r & sda_d_r & ~sda_in;
   assign stop_cond = scl_in & scl_d_r & ~sda_d_r & sda_in;

   // Status sampling; reserved bits read as zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         charge_stat_r <= cstat_pkg::CSTAT_REG_RESET;
         fault_stat_r <= cstat_pkg::CSTAT_REG_RESET;
         sensor_stat_r <= cstat_pkg::CSTAT_REG_RESET;
      end else begin
         charge_stat_r <= cstat_pkg::CSTAT_REG_RESET;
         fault_stat_r <= cstat_pkg::CSTAT_REG_RESET;
         sensor_stat_r <= cstat_pkg::CSTAT_REG_RESET;
         charge_stat_r[cstat_pkg::CSTAT_CV_BIT] <= constant_voltage_active;
         charge_stat_r[cstat_pkg::CSTAT_PGOOD_BIT] <= input_power_good;
         charge_stat_r[cstat_pkg::CSTAT_ILIM_BIT] <= input_current_limit_active;
         charge_stat_r[cstat_pkg::CSTAT_DONE_BIT] <= charge_done;
         charge_stat_r[cstat_pkg::CSTAT_VREG_BIT] <= input_voltage_regulation_active;
         charge_stat_r[cstat_pkg::CSTAT_THERM_BIT] <= die_thermal_regulation_active;
         fault_stat_r[cstat_pkg::CSTAT_OVP_BIT] <= input_overvoltage_active;
         fault_stat_r[cstat_pkg::CSTAT_OCP_BIT] <= battery_overcurrent_active;
         fault_stat_r[cstat_pkg::CSTAT_UVLO_BIT] <= battery_undervoltage_active;
         fault_stat_r[cstat_pkg::CSTAT_COLD_BIT] <= thermistor_cold_zone;
         fault_stat_r[cstat_pkg::CSTAT_COOL_BIT] <= thermistor_cool_zone;
         fault_stat_r[cstat_pkg::CSTAT_WARM_BIT] <= thermistor_warm_zone;
         fault_stat_r[cstat_pkg::CSTAT_HOT_BIT] <= thermistor_hot_zone;
         sensor_stat_r[cstat_pkg::CSTAT_OPEN_BIT] <= thermistor_open_detect;
      end
   end

   // Thermal zone actions on charging; cold and hot both stop charging
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         suspend_r <= 1'b0;
         cur_red_r <= 1'b0;
         volt_red_r <= 1'b0;
      end else begin
         suspend_r <= thermistor_cold_zone | thermistor_hot_zone;
         cur_red_r <= thermistor_cool_zone;
         volt_red_r <= thermistor_warm_zone;
      end
   end

   // Pin history
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_in;
         sda_d_r <= sda_in;
      end
   end

   // Register read decode; unmapped addresses return zero
   always_comb begin
      unique case (ptr_r)
         cstat_pkg::CSTAT_CHARGE_REG_OFS: rd_data = charge_stat_r;
         cstat_pkg::CSTAT_FAULT_REG_OFS: rd_data = fault_stat_r;
         cstat_pkg::CSTAT_SENSOR_REG_OFS: rd_data = sensor_stat_r;
         default: rd_data = cstat_pkg::CSTAT_REG_RESET;
      endcase
   end

   // Serial engine; data changes on falling clock, sampled on rising
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= cstat_pkg::CSTAT_IDLE;
         after_ack_r <= cstat_pkg::CSTAT_IDLE;
         bit_cnt_r <= 4'h0;
         rx_r <= 8'h00;
         tx_r <= 8'h00;
         ptr_r <= cstat_pkg::CSTAT_CHARGE_REG_OFS;
         sda_oe_n_r <= 1'b1;
      end else if (stop_cond) begin
         // Stop always releases the line
         state_r <= cstat_pkg::CSTAT_IDLE;
         sda_oe_n_r <= 1'b1;
      end else if (start_cond) begin
         // Start or repeated start; the pointer is kept
         state_r <= cstat_pkg::CSTAT_ADDR;
         bit_cnt_r <= 4'h0;
         sda_oe_n_r <= 1'b1;
      end else begin
         unique case (state_r)
            cstat_pkg::CSTAT_IDLE: begin
               sda_oe_n_r <= 1'b1;
            end
            cstat_pkg::CSTAT_ADDR, cstat_pkg::CSTAT_PTR, cstat_pkg::CSTAT_WDATA: begin
               if (scl_rise) begin
                  rx_r <= {rx_r[6:0], sda_in};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall && bit_cnt_r == cstat_pkg::CSTAT_BYTE_BITS) begin
                  bit_cnt_r <= 4'h0;
                  if (state_r == cstat_pkg::CSTAT_ADDR) begin
                     if (rx_r[7:1] == TARGET_ADDR) begin
                        sda_oe_n_r <= 1'b0;
                        state_r <= cstat_pkg::CSTAT_ACK;
                        after_ack_r <= rx_r[0] ? cstat_pkg::CSTAT_READ : cstat_pkg::CSTAT_PTR;
                     end else begin
                        // Another target is addressed; stay off the bus
                        state_r <= cstat_pkg::CSTAT_IDLE;
                     end
                  end else begin
                     // Pointer byte loads; written data is ignored, registers are read-only
                     if (state_r == cstat_pkg::CSTAT_PTR) begin
                        ptr_r <= rx_r;
                     end else begin
                        ptr_r <= ptr_r + 8'h01;
                     end
                     sda_oe_n_r <= 1'b0;
                     state_r <= cstat_pkg::CSTAT_ACK;
                     after_ack_r <= cstat_pkg::CSTAT_WDATA;
                  end
               end
            end
            cstat_pkg::CSTAT_ACK: begin
               if (scl_fall) begin
                  if (after_ack_r == cstat_pkg::CSTAT_READ) begin
                     // Snapshot the byte at its start so it cannot tear
                     tx_r <= {rd_data[6:0], 1'b0};
                     sda_oe_n_r <= rd_data[7];
                     ptr_r <= ptr_r + 8'h01;
                     bit_cnt_r <= 4'h1;
                  end else begin
                     sda_oe_n_r <= 1'b1;
                  end
                  state_r <= after_ack_r;
               end
            end
            cstat_pkg::CSTAT_READ: begin
               if (scl_fall) begin
                  if (bit_cnt_r == cstat_pkg::CSTAT_BYTE_BITS) begin
                     sda_oe_n_r <= 1'b1;
                     state_r <= cstat_pkg::CSTAT_RACK;
                  end else begin
                     sda_oe_n_r <= tx_r[7];
                     tx_r <= {tx_r[6:0], 1'b0};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
            end
            cstat_pkg::CSTAT_RACK: begin
               if (scl_rise && sda_in) begin
                  // Host refused the byte; wait for stop or start
                  state_r <= cstat_pkg::CSTAT_IDLE;
               end else if (scl_fall) begin
                  tx_r <= {rd_data[6:0], 1'b0};
                  sda_oe_n_r <= rd_data[7];
                  ptr_r <= ptr_r + 8'h01;
                  bit_cnt_r <= 4'h1;
                  state_r <= cstat_pkg::CSTAT_READ;
               end
            end
         endcase
      end
   end

   // Open-drain data only ever pulls low
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sda_out_r <= 1'b0;
      end else begin
         sda_out_r <= 1'b0;
      end
   end

   assign sda_out = sda_out_r;
   assign sda_oe_n = sda_oe_n_r;
   assign charge_suspend = suspend_r;
   assign charge_current_reduce = cur_red_r;
   assign charge_voltage_reduce = volt_red_r;
endmodule : cstat_status_regs
`default_nettype wire

/* File: verif/cstat_status_regs_properties.sv */
// Port checker for the charger status bank
`default_nettype none
module cstat_status_regs_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Thermistor zones and controls
   input wire logic thermistor_cold_zone,
   input wire logic thermistor_cool_zone,
   input wire logic thermistor_warm_zone,
   input wire logic thermistor_hot_zone,
   input wire logic charge_suspend,
   input wire logic charge_current_reduce,
   input wire logic charge_voltage_reduce,
   // Serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Start and stop need the bus clock high on two samples
   sequence start_seen;
      scl_in && $past(scl_in) && $fell(sda_in);
   endsequence
   sequence stop_seen;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   a_suspend_on_zone: assert property ((thermistor_cold_zone || thermistor_hot_zone) |=> charge_suspend)
      else $error("suspend missing");
   a_suspend_off_zone: assert property (!(thermistor_cold_zone || thermistor_hot_zone) |=> !charge_suspend)
      else $error("suspend without zone");
   a_cool_cuts_current: assert property (thermistor_cool_zone |=> charge_current_reduce)
      else $error("current reduce missing");
   a_warm_cuts_voltage: assert property (thermistor_warm_zone |=> charge_voltage_reduce)
      else $error("voltage reduce missing");
   a_data_moves_low: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data moved while bus clock high");
   a_drive_only_low: assert property (!sda_oe_n |-> !sda_out)
      else $error("data driven high");
   a_stop_line_free: assert property (stop_seen |-> sda_oe_n)
      else $error("line held at stop");
   a_start_line_free: assert property (start_seen |=> sda_oe_n)
      else $error("line held after start");
endmodule : cstat_status_regs_checker
bind cstat_status_regs cstat_status_regs_checker cstat_status_regs_checker_i (
   .clk, .arst_n, .thermistor_cold_zone, .thermistor_cool_zone, .thermistor_warm_zone,
   .thermistor_hot_zone, .charge_suspend, .charge_current_reduce, .charge_voltage_reduce,
   .scl_in, .sda_in, .sda_out, .sda_oe_n
);
`default_nettype wire

/* File: verif/cstat_host_model.sv */
// Serial host model that talks to the status bank
`default_nettype none
module cstat_host_model (
   // Clock and resolved data line
   input wire logic clk,
   input wire logic sda,
   // Host pins, data is open drain
   output logic scl,
   output logic sda_drv
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idles released
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Phases of 4 clocks stay above the 3 clock minimum
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   // Start or repeated start: data falls under a high clock
   task automatic start_cond();
      sda_drv = 1'b1;
      tick(2);
      scl = 1'b1;
      tick(4);
      sda_drv = 1'b0;
      tick(4);
      scl = 1'b0;
      tick(2);
   endtask : start_cond
   // Stop: data rises under a high clock
   task automatic stop_cond();
      sda_drv = 1'b0;
      tick(2);
      scl = 1'b1;
      tick(4);
      sda_drv = 1'b1;
      tick(4);
   endtask : stop_cond
   // Byte MSB first, then a ninth bit; a 1 there lets the target answer
   task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q, output logic a);
      for (int i = 8; i >= 0; i--) begin
         sda_drv = (i == 0) ? b9 : d[i - 1];
         tick(4);
         scl = 1'b1;
         tick(4);
         if (i == 0) a = sda;
         else q[i - 1] = sda;
         scl = 1'b0;
         tick(2);
      end
   endtask : xfer
endmodule : cstat_host_model
`default_nettype wire

/* File: verif/cstat_status_regs_bench.sv */
// Self-checking bench for the charger status bank
`default_nettype none
module cstat_status_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, arst_n, scl, sda_drv, sda, sda_out, sda_oe_n, a;
   logic charge_suspend, charge_current_reduce, charge_voltage_reduce;
   logic [13:0] stim; // Status inputs, bit order as in exp_reg
   logic [7:0] q, d;
   int n_errors = 0, checks = 0, cycles = 0;
   // Wired-AND with pull-up
   assign sda = sda_drv & (sda_oe_n | sda_out);
   cstat_status_regs cstat_status_regs_i (
      .clk, .arst_n, .constant_voltage_active(stim[0]), .charge_done(stim[1]),
      .input_current_limit_active(stim[2]), .input_voltage_regulation_active(stim[3]),
      .die_thermal_regulation_active(stim[4]), .input_power_good(stim[5]),
      .input_overvoltage_active(stim[6]), .battery_overcurrent_active(stim[7]),
      .battery_undervoltage_active(stim[8]), .thermistor_cold_zone(stim[9]), .thermistor_cool_zone(stim[10]),
      .thermistor_warm_zone(stim[11]), .thermistor_hot_zone(stim[12]), .thermistor_open_detect(stim[13]),
      .charge_suspend, .charge_current_reduce, .charge_voltage_reduce,
      .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n
   );
   cstat_host_model cstat_host_model_i (.clk, .sda, .scl, .sda_drv);
   always #4 clk = ~clk;
   // Expected register content; reserved bits read 0
   function automatic logic [7:0] exp_reg(input logic [7:0] o, input logic [13:0] s);
      case (o)
         8'h00: exp_reg = {1'b0, s[0], s[1], s[2], 1'b0, s[3], s[4], s[5]};
         8'h01: exp_reg = {s[6], 1'b0, s[7], s[8], s[9], s[10], s[11], s[12]};
         8'h02: exp_reg = {7'h00, s[13]};
         default: exp_reg = 8'h00; // Unmapped offsets read zero
      endcase
   endfunction : exp_reg
   task automatic cmp_byte(input string w, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask : cmp_byte
   task automatic cmp_bit(input string w, input logic e, input logic g);
      cmp_byte(w, {7'h00, e}, {7'h00, g});
   endtask : cmp_bit
   // Header: start and address byte, acknowledge checked
   task automatic head(input logic rd);
      cstat_host_model_i.start_cond();
      cstat_host_model_i.xfer({cstat_pkg::CSTAT_TARGET_ADDR, rd}, 1'b1, d, a);
      cmp_bit("address ack", 1'b0, a);
   endtask : head
   // Pointer write, repeated start, one byte read with NACK
   task automatic reg_read(input logic [7:0] o, output logic [7:0] v);
      head(1'b0);
      cstat_host_model_i.xfer(o, 1'b1, d, a);
      head(1'b1);
      cstat_host_model_i.xfer(8'hff, 1'b1, v, a);
      cstat_host_model_i.stop_cond();
   endtask : reg_read
   task automatic final_report();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   // Ceiling well above the roughly 25000 cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      stim = 14'h0000;
      repeat (16) @(negedge clk);
      cmp_bit("oe in reset", 1'b1, sda_oe_n);
      cmp_bit("suspend in reset", 1'b0, charge_suspend);
      arst_n = 1'b1;
      repeat (2) @(negedge clk);
      // Walking one over every input, then all set
      for (int i = 0; i <= 14; i++) begin
         stim = (i == 14) ? 14'h3fff : 14'h0001 << i;
         repeat (2) @(negedge clk);
         cmp_bit("suspend", stim[9] | stim[12], charge_suspend);
         cmp_bit("current reduce", stim[10], charge_current_reduce);
         cmp_bit("voltage reduce", stim[11], charge_voltage_reduce);
         for (int r = 0; r < 4; r++) begin
            reg_read(r[7:0], q);
            cmp_byte("status reg", exp_reg(r[7:0], stim), q);
         end
         $display("test walk %0d done", i);
      end
      // Pointer kept over a stop, then a burst read with host acknowledge walks it
      stim = 14'h2a55;
      repeat (2) @(negedge clk);
      head(1'b0);
      cstat_host_model_i.xfer(cstat_pkg::CSTAT_FAULT_REG_OFS, 1'b1, d, a);
      cmp_bit("pointer ack", 1'b0, a);
      cstat_host_model_i.stop_cond();
      head(1'b1);
      for (int r = 1; r < 4; r++) begin
         cstat_host_model_i.xfer(8'hff, r == 3, q, a);
         cmp_byte("burst reg", exp_reg(r[7:0], stim), q);
      end
      cstat_host_model_i.stop_cond();
      $display("test burst read done");
      // Foreign address gets no acknowledge
      cstat_host_model_i.start_cond();
      cstat_host_model_i.xfer({cstat_pkg::CSTAT_TARGET_ADDR ^ 7'h01, 1'b0}, 1'b1, d, a);
      cmp_bit("foreign ack", 1'b1, a);
      cstat_host_model_i.stop_cond();
      // Write to a read-only register leaves it live
      stim = 14'h0000;
      head(1'b0);
      cstat_host_model_i.xfer(8'h00, 1'b1, d, a);
      cstat_host_model_i.xfer(8'hff, 1'b1, d, a);
      cmp_bit("data ack", 1'b0, a);
      cstat_host_model_i.stop_cond();
      reg_read(8'h00, q);
      cmp_byte("after write", 8'h00, q);
      $display("test address and write done");
      final_report();
   end
endmodule : cstat_status_regs_bench
`default_nettype wire
